// file: verilog/standby_clock_defines.svh
// Register offsets, field positions, reset values and timing counts of the standby clock block
`ifndef STANDBY_CLOCK_DEFINES_SVH
`define STANDBY_CLOCK_DEFINES_SVH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define ADDR_STANDBY_CLOCK_CTRL 16'hFF84
`define ADDR_MODULE_HALT_CTRL 16'hFF80
`define ADDR_POWER_STATUS 16'hFF90
`define ADDR_DECODE_BITS 16

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define CTRL_WIDTH 8
`define CTRL_RESET 8'h00
`define CTRL_WRITE_MASK 8'hF7
`define MODULE_HALT_WIDTH 16
`define MODULE_HALT_RESET 16'h0000
`define STATUS_STATE_LSB 0
`define STATUS_BUSY_BIT 2

// ----------------------------------------------------------------
// Clock select codes
// ----------------------------------------------------------------
`define DIV_FULL_SPEED 3'h0
`define DIV_CODE_MAX 3'h5

// ----------------------------------------------------------------
// Settling times in states of the system clock
// ----------------------------------------------------------------
`define WAIT_WIDTH 19
`define WAIT_CODE0 8192
`define WAIT_CODE1 16384
`define WAIT_CODE2 32768
`define WAIT_CODE3 65536
`define WAIT_CODE4 131072
`define WAIT_CODE5 262144
`define WAIT_CODE7 16
`define WAIT_CODE_RESERVED 3'h6

`endif

// file: verilog/standby_clock_pkg.sv
// Types shared by the standby clock control block
package standby_clock_pkg;

   // Layout of the standby control register, bit 7 first
   typedef struct packed {
      logic standby_select_bit;
      logic [2:0] wake_wait_sel;
      logic reserved;
      logic [2:0] bus_clk_div_sel;
   } standby_ctrl_s;

   // Captured address phase of an AHB-Lite transfer
   typedef struct packed {
      logic valid;
      logic write;
      logic [15:0] addr;
   } ahb_addr_phase_s;

   // Power state, Gray coded along run, standby, settle
   typedef enum logic [1:0] {
      ST_RUN = 2'b00,
      ST_STANDBY = 2'b01,
      ST_SETTLE = 2'b11,
      ST_SLEEP = 2'b10
   } power_state_e;

endpackage : standby_clock_pkg

// file: verilog/bus_clk_divider.sv
// Clock enable generator for the bus master, full speed down to system clock over 32
`timescale 1ns/100ps
`default_nettype none
`include "standby_clock_defines.svh"

module bus_clk_divider
   import standby_clock_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic run,
   input wire logic [2:0] div_sel,
   output logic tick
);

   logic [4:0] count_reg;
   logic tick_reg;

   // Codes above the last divider fall back to full speed
   function automatic logic [4:0] div_mask(input logic [2:0] sel);
      logic [4:0] m;
      m = 5'h00;
      if (sel <= `DIV_CODE_MAX) begin
         m = 5'(( 6'h01 << sel) - 6'h01);
      end
      return m;
   endfunction : div_mask

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         count_reg <= 5'h00;
      end else begin
         count_reg <= count_reg + 5'h01;
      end
   end

   // One enable every 2^code cycles for codes 0 to 5, and none while the core clock is off
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tick_reg <= 1'b0;
      end else begin
         tick_reg <= run && ((count_reg & div_mask(div_sel)) == div_mask(div_sel));
      end
   end

   assign tick = tick_reg;

endmodule : bus_clk_divider
`default_nettype wire

// file: verilog/wake_wait_timer.sv
// Down counter that times the oscillator settling wait after a standby exit
`timescale 1ns/100ps
`default_nettype none
`include "standby_clock_defines.svh"

module wake_wait_timer
   import standby_clock_pkg::*;
#(
   parameter int WIDTH = `WAIT_WIDTH
)
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic start,
   input wire logic [WIDTH-1:0] load,
   output logic busy,
   output logic done
);

   logic [WIDTH-1:0] count_reg;
   logic busy_reg;
   logic done_reg;

   // Busy stands for exactly load cycles after the start edge
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         count_reg <= '0;
         busy_reg <= 1'b0;
         done_reg <= 1'b0;
      end else begin
         done_reg <= 1'b0;
         if (start) begin
            count_reg <= load - WIDTH'(1);
            busy_reg <= 1'b1;
         end else if (busy_reg) begin
            if (count_reg == '0) begin
               busy_reg <= 1'b0;
               done_reg <= 1'b1;
            end else begin
               count_reg <= count_reg - WIDTH'(1);
            end
         end
      end
   end

   assign busy = busy_reg;
   assign done = done_reg;

endmodule : wake_wait_timer
`default_nettype wire

// file: verilog/standby_clock_control.sv
// Standby and clock control: register file over AHB-Lite, power states, module stop
//
// The AHB-Lite slave port was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "standby_clock_defines.svh"

module standby_clock_control
   import standby_clock_pkg::*;
#(
   parameter int WAIT_CODE0 = `WAIT_CODE0,
   parameter int WAIT_CODE1 = `WAIT_CODE1,
   parameter int WAIT_CODE2 = `WAIT_CODE2,
   parameter int WAIT_CODE3 = `WAIT_CODE3,
   parameter int WAIT_CODE4 = `WAIT_CODE4,
   parameter int WAIT_CODE5 = `WAIT_CODE5,
   parameter int WAIT_CODE7 = `WAIT_CODE7
)
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic halt_instr,
   input wire logic wake_event,
   output logic bus_clk_en,
   output logic core_clk_run,
   output logic osc_enable,
   output logic sleep_active,
   output logic standby_active,
   output logic [`MODULE_HALT_WIDTH-1:0] module_halt
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   standby_ctrl_s ctrl_reg;
   standby_ctrl_s ctrl_next;
   logic [`MODULE_HALT_WIDTH-1:0] module_halt_reg;
   logic [`MODULE_HALT_WIDTH-1:0] module_halt_next;
   ahb_addr_phase_s aphase_reg;
   logic [31:0] hrdata_reg;
   logic hreadyout_reg;
   logic hresp_reg;
   power_state_e state_reg;
   power_state_e state_next;
   logic core_clk_run_reg;
   logic osc_enable_reg;
   logic sleep_active_reg;
   logic standby_active_reg;
   logic [`MODULE_HALT_WIDTH-1:0] module_halt_q;
   logic timer_start;
   logic timer_busy;
   logic timer_done;
   logic [`WAIT_WIDTH-1:0] wait_load;
   logic addr_take;
   logic write_data_phase;
   logic [31:0] read_value;

   // ----------------------------------------------------------------
   // Helper functions
   // ----------------------------------------------------------------

   // Settling wait in states for a wait select code
   // Reserved code 110 falls back to the code 5 wait, the longest at the default counts, the safe side for the oscillator
   function automatic logic [`WAIT_WIDTH-1:0] wait_states(input logic [2:0] sel);
      logic [`WAIT_WIDTH-1:0] n;
      n = `WAIT_WIDTH'(WAIT_CODE5);
      unique case (sel)
         3'h0: n = `WAIT_WIDTH'(WAIT_CODE0);
         3'h1: n = `WAIT_WIDTH'(WAIT_CODE1);
         3'h2: n = `WAIT_WIDTH'(WAIT_CODE2);
         3'h3: n = `WAIT_WIDTH'(WAIT_CODE3);
         3'h4: n = `WAIT_WIDTH'(WAIT_CODE4);
         3'h5: n = `WAIT_WIDTH'(WAIT_CODE5);
         3'h6: n = `WAIT_WIDTH'(WAIT_CODE5);
         3'h7: n = `WAIT_WIDTH'(WAIT_CODE7);
      endcase
      return n;
   endfunction : wait_states

   // Register decode on the low 16 bits of the byte address, bits 1:0 included
   function automatic logic addr_is(input logic [15:0] a, input logic [15:0] reg_addr);
      return a == reg_addr;
   endfunction : addr_is

   // ----------------------------------------------------------------
   // AHB-Lite address and data phase tracking
   // ----------------------------------------------------------------

   // Only the high half of htrans matters: NONSEQ or SEQ
   assign addr_take = hsel && hready && htrans[1];
   assign write_data_phase = aphase_reg.valid && aphase_reg.write;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         aphase_reg <= '0;
      end else if (hready) begin
         aphase_reg.valid <= addr_take;
         aphase_reg.write <= hwrite;
         aphase_reg.addr <= haddr[`ADDR_DECODE_BITS-1:0];
      end
   end

   // Zero wait states and always OKAY; these stay constant after reset
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout_reg <= 1'b1;
         hresp_reg <= 1'b0;
      end else begin
         hreadyout_reg <= 1'b1;
         hresp_reg <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Register writes
   // ----------------------------------------------------------------

   // Bit 3 of the control register is not stored and reads as zero
   always_comb begin
      ctrl_next = ctrl_reg;
      if (write_data_phase && addr_is(aphase_reg.addr, `ADDR_STANDBY_CLOCK_CTRL)) begin
         ctrl_next = standby_ctrl_s'(hwdata[`CTRL_WIDTH-1:0] & `CTRL_WRITE_MASK);
      end
   end

   // Unassigned stop bits are stored like the others, whatever software writes
   always_comb begin
      module_halt_next = module_halt_reg;
      if (write_data_phase && addr_is(aphase_reg.addr, `ADDR_MODULE_HALT_CTRL)) begin
         module_halt_next = hwdata[`MODULE_HALT_WIDTH-1:0];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_reg <= standby_ctrl_s'(`CTRL_RESET);
      end else begin
         ctrl_reg <= ctrl_next;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         module_halt_reg <= `MODULE_HALT_RESET;
      end else begin
         module_halt_reg <= module_halt_next;
      end
   end

   // ----------------------------------------------------------------
   // Register reads
   // ----------------------------------------------------------------

   // Control and stop reads use the next values, so a read right behind a write sees the new data
   always_comb begin
      read_value = 32'h0000_0000;
      if (addr_is(haddr[`ADDR_DECODE_BITS-1:0], `ADDR_STANDBY_CLOCK_CTRL)) begin
         read_value = {24'h00_0000, ctrl_next};
      end else if (addr_is(haddr[`ADDR_DECODE_BITS-1:0], `ADDR_MODULE_HALT_CTRL)) begin
         read_value = {16'h0000, module_halt_next};
      end else if (addr_is(haddr[`ADDR_DECODE_BITS-1:0], `ADDR_POWER_STATUS)) begin
         read_value = {29'h0000_0000, timer_busy, state_reg};
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_reg <= 32'h0000_0000;
      end else if (addr_take && !hwrite) begin
         hrdata_reg <= read_value;
      end
   end

   // ----------------------------------------------------------------
   // Power state machine
   // ----------------------------------------------------------------

   // Halt is honoured only while running, at full or divided speed
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         ST_RUN: begin
            if (halt_instr) begin
               if (ctrl_reg.standby_select_bit) begin
                  state_next = ST_STANDBY;
               end else begin
                  state_next = ST_SLEEP;
               end
            end
         end
         ST_SLEEP: begin
            if (wake_event) begin
               state_next = ST_RUN;
            end
         end
         ST_STANDBY: begin
            if (wake_event) begin
               state_next = ST_SETTLE;
            end
         end
         ST_SETTLE: begin
            if (timer_done) begin
               state_next = ST_RUN;
            end
         end
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_reg <= ST_RUN;
      end else begin
         state_reg <= state_next;
      end
   end

   // ----------------------------------------------------------------
   // Settling wait
   // ----------------------------------------------------------------

   // Selection is sampled when the wake arrives; later writes do not stretch it
   assign timer_start = (state_reg == ST_STANDBY) && wake_event;
   assign wait_load = wait_states(ctrl_reg.wake_wait_sel);

   wake_wait_timer #(
      .WIDTH(`WAIT_WIDTH)
   ) u_wake_wait_timer (
      .hclk(hclk),
      .hresetn(hresetn),
      .start(timer_start),
      .load(wait_load),
      .busy(timer_busy),
      .done(timer_done)
   );

   // ----------------------------------------------------------------
   // Clock and power outputs
   // ----------------------------------------------------------------

   // Core clock stays gated through standby and the whole settling wait
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         core_clk_run_reg <= 1'b1;
         osc_enable_reg <= 1'b1;
         sleep_active_reg <= 1'b0;
         standby_active_reg <= 1'b0;
      end else begin
         core_clk_run_reg <= (state_next == ST_RUN);
         osc_enable_reg <= (state_next != ST_STANDBY);
         sleep_active_reg <= (state_next == ST_SLEEP);
         standby_active_reg <= (state_next == ST_STANDBY);
      end
   end

   bus_clk_divider u_bus_clk_divider (
      .hclk(hclk),
      .hresetn(hresetn),
      .run(state_next == ST_RUN),
      .div_sel(ctrl_reg.bus_clk_div_sel),
      .tick(bus_clk_en)
   );

   // A stop bit of 1 halts its module, 0 lets it run
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         module_halt_q <= `MODULE_HALT_RESET;
      end else begin
         module_halt_q <= module_halt_next;
      end
   end

   assign hrdata = hrdata_reg;
   assign hreadyout = hreadyout_reg;
   assign hresp = hresp_reg;
   assign core_clk_run = core_clk_run_reg;
   assign osc_enable = osc_enable_reg;
   assign sleep_active = sleep_active_reg;
   assign standby_active = standby_active_reg;
   assign module_halt = module_halt_q;

endmodule : standby_clock_control
`default_nettype wire

// file: verif/standby_clock_control_properties.sv
// Concurrent checks on the power and bus outputs of the standby clock block
`timescale 1ns/100ps
`default_nettype none

module standby_clock_control_properties (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic halt_instr,
   input wire logic wake_event,
   input wire logic bus_clk_en,
   input wire logic core_clk_run,
   input wire logic osc_enable,
   input wire logic sleep_active,
   input wire logic standby_active
);
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   // ---------------------------------------------------------------
   // Steps of a standby exit
   // ---------------------------------------------------------------
   sequence s_settling;
      !standby_active && osc_enable && !core_clk_run;
   endsequence
   // Shortest wait in this build is 16, so the core stays off longer than this
   sequence s_core_off;
      !core_clk_run [*3];
   endsequence

   property p_bus_okay;
      hreadyout && !hresp;
   endproperty
   a_bus_okay: assert property (p_bus_okay)
      else $error("bus slave not ready or not okay");
   property p_halt_enters;
      core_clk_run && halt_instr |=> (sleep_active ^ standby_active) && !core_clk_run;
   endproperty
   a_halt_enters: assert property (p_halt_enters)
      else $error("halt did not leave run state");
   property p_sleep_osc;
      sleep_active |-> osc_enable && !core_clk_run && !standby_active;
   endproperty
   a_sleep_osc: assert property (p_sleep_osc)
      else $error("sleep state outputs wrong");
   property p_standby_osc;
      standby_active |-> !osc_enable && !core_clk_run;
   endproperty
   a_standby_osc: assert property (p_standby_osc)
      else $error("standby state outputs wrong");
   property p_sleep_wake;
      sleep_active && wake_event |=> core_clk_run && !sleep_active;
   endproperty
   a_sleep_wake: assert property (p_sleep_wake)
      else $error("wake from sleep not taken");
   property p_standby_wake;
      standby_active && wake_event |=> s_settling ##1 s_core_off;
   endproperty
   a_standby_wake: assert property (p_standby_wake)
      else $error("standby exit did not hold the core off");
   property p_clk_en_stops;
      !core_clk_run && !$past(core_clk_run) |-> !bus_clk_en;
   endproperty
   a_clk_en_stops: assert property (p_clk_en_stops)
      else $error("bus clock enable while stopped");
   property p_run_holds;
      core_clk_run && !halt_instr |=> core_clk_run;
   endproperty
   a_run_holds: assert property (p_run_holds)
      else $error("run state left without halt");
   property p_settle_osc;
      !core_clk_run && !sleep_active && !standby_active |-> osc_enable;
   endproperty
   a_settle_osc: assert property (p_settle_osc)
      else $error("oscillator off while settling");
endmodule : standby_clock_control_properties

bind standby_clock_control standby_clock_control_properties i_standby_clock_control_properties (
   .hclk(hclk),
   .hresetn(hresetn),
   .hreadyout(hreadyout),
   .hresp(hresp),
   .halt_instr(halt_instr),
   .wake_event(wake_event),
   .bus_clk_en(bus_clk_en),
   .core_clk_run(core_clk_run),
   .osc_enable(osc_enable),
   .sleep_active(sleep_active),
   .standby_active(standby_active)
);

`default_nettype wire

// file: verif/tb_standby_clock_control.sv
// Self-checking bench for the standby clock control block
`timescale 1ns/100ps
`default_nettype none
`include "standby_clock_defines.svh"
`define CHK(a, e, m) begin check_count++; if ((a) !== (e)) begin bad_count++; \
   $display("unexpected at %0t: %s", $time, m); end end

module tb_standby_clock_control;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic hreadyout;
   logic hresp;
   logic halt_instr = 1'b0;
   logic wake_event = 1'b0;
   logic bus_clk_en;
   logic core_clk_run;
   logic osc_enable;
   logic sleep_active;
   logic standby_active;
   logic [15:0] module_halt;
   logic [31:0] rd;
   int bad_count = 0;
   int check_count = 0;
   // Codes 1 to 5 shortened, reserved code 6 follows code 5, codes 0 and 7 as built
   int waits [8] = '{8192, 16, 32, 64, 128, 256, 256, 16};

   standby_clock_control #(.WAIT_CODE1(16), .WAIT_CODE2(32), .WAIT_CODE3(64),
      .WAIT_CODE4(128), .WAIT_CODE5(256))
   i_standby_clock_control (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .halt_instr(halt_instr),
      .wake_event(wake_event), .bus_clk_en(bus_clk_en), .core_clk_run(core_clk_run),
      .osc_enable(osc_enable), .sleep_active(sleep_active),
      .standby_active(standby_active), .module_halt(module_halt));

   always #2 hclk = ~hclk;

   // ---------------------------------------------------------------
   // Drivers
   // ---------------------------------------------------------------
   task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] d);
      @(posedge hclk);
      htrans <= 2'h2;
      haddr <= {16'h0000, a};
      hwrite <= w;
      hsize <= 3'h2;
      hsel <= 1'b1;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : bus

   // Leaves time just after the edge that took the pulse
   task automatic pulse(input bit wk);
      @(posedge hclk);
      if (wk) wake_event <= 1'b1;
      else halt_instr <= 1'b1;
      @(posedge hclk);
      wake_event <= 1'b0;
      halt_instr <= 1'b0;
      #1;
   endtask : pulse

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_regs;
      bus(1'b0, `ADDR_STANDBY_CLOCK_CTRL, 32'h0);
      `CHK(rd, 32'h0, "control reset value")
      bus(1'b1, `ADDR_STANDBY_CLOCK_CTRL, 32'hFF);
      bus(1'b0, `ADDR_STANDBY_CLOCK_CTRL, 32'h0);
      `CHK(rd, 32'hF7, "control readback, bit 3 reads zero")
      bus(1'b1, 16'hFF00, 32'hFF);
      bus(1'b0, 16'hFF00, 32'h0);
      `CHK(rd, 32'h0, "unmapped read")
      bus(1'b1, `ADDR_STANDBY_CLOCK_CTRL, 32'h0);
      `CHK(module_halt, 16'h0000, "module stop reset")
      bus(1'b1, `ADDR_MODULE_HALT_CTRL, 32'hFFFF);
      bus(1'b0, `ADDR_MODULE_HALT_CTRL, 32'h0);
      `CHK(rd, 32'hFFFF, "unassigned stop bits read back")
      repeat (2) @(posedge hclk);
      #1;
      `CHK(module_halt, 16'hFFFF, "module stop output")
      // Unassigned stop bits stay at 1 while the assigned ones are released
      bus(1'b1, `ADDR_MODULE_HALT_CTRL, 32'hC465);
      repeat (2) @(posedge hclk);
      #1;
      `CHK(module_halt, 16'hC465, "module stop released")
   endtask : t_regs

   task automatic t_div;
      int m;
      for (int c = 0; c < 8; c++) begin
         bus(1'b1, `ADDR_STANDBY_CLOCK_CTRL, c);
         m = 0;
         do begin
            @(posedge hclk);
            #1;
            m++;
         end while (bus_clk_en !== 1'b1 && m < 100);
         m = 0;
         do begin
            @(posedge hclk);
            #1;
            m++;
         end while (bus_clk_en !== 1'b1 && m < 100);
         `CHK(m, (c > 5) ? 1 : (1 << c), "bus clock period")
      end
   endtask : t_div

   task automatic t_power;
      int n;
      bus(1'b1, `ADDR_STANDBY_CLOCK_CTRL, 32'h0);
      pulse(1'b0);
      `CHK({sleep_active, standby_active, core_clk_run}, 3'b100, "sleep entry")
      pulse(1'b1);
      `CHK({sleep_active, core_clk_run}, 2'b01, "sleep exit")
      for (int c = 0; c < 8; c++) begin
         bus(1'b1, `ADDR_STANDBY_CLOCK_CTRL, 32'h80 | (c << 4));
         pulse(1'b0);
         `CHK({standby_active, sleep_active, osc_enable}, 3'b100, "standby entry")
         pulse(1'b1);
         n = 0;
         while (core_clk_run !== 1'b1 && n < 10000) begin
            @(posedge hclk);
            #1;
            n++;
         end
         // Timer busy for the wait, one more edge for the done pulse to restart the core
         `CHK(n, waits[c] + 1, "settling wait length")
      end
   endtask : t_power

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : tally_and_finish

   initial begin
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      t_regs();
      t_div();
      t_power();
      tally_and_finish();
   end

   // The run needs about ten thousand cycles; this cuts a hang short
   initial begin
      #200000;
      bad_count++;
      tally_and_finish();
   end
endmodule : tb_standby_clock_control

`default_nettype wire
